// File: src/amp_mode_defines.vh
// constants for the amplifier mode and clock source control block
`ifndef AMP_MODE_DEFINES_VH
`define AMP_MODE_DEFINES_VH

// ==========================================================
// amplifier state codes
`define AMP_OFF 2'h0
`define AMP_STANDBY 2'h1
`define AMP_MUTE 2'h2
`define AMP_OPERATE 2'h3

// ==========================================================
// clock and watchdog timing
`define CORE_CLK_PERIOD_NS 10
`define OSC_DIV_HALF 8'h9c
`define WDOG_TIMEOUT_NS 10000
`define WDOG_TIMEOUT_CYC (`WDOG_TIMEOUT_NS / `CORE_CLK_PERIOD_NS)
`define WDOG_CNT_W 11
`define WDOG_LAST_CNT 11'h3e7

// ==========================================================
// command byte bit index
`define CMD_BIT0 0

`endif

// File: src/amp_mode_ctrl.v
// amplifier mode control, clock master/slave selection and clock-loss watchdog
`timescale 1ns/10ps
`default_nettype none
`include "amp_mode_defines.vh"

module amp_mode_ctrl (
    input wire core_clk_i,
    input wire rst_i,
    input wire clk_en_i,
    input wire enable_pin_i,
    input wire mute_select_pin_i,
    input wire address_select_pin_i,
    input wire oscillator_set_pin_i,
    input wire spread_or_pll_pin_i,
    input wire shared_oscillator_pin_i,
    input wire first_cmd_byte_bit0_i,
    input wire second_cmd_byte_bit0_i,
    input wire cmd_valid_i,
    input wire hop_req_i,
    input wire load_detect_req_i,
    input wire ext_cfg_req_i,
    output reg shared_oscillator_pin_o,
    output reg shared_oscillator_pin_oe_o,
    output reg [1:0] amp_state_o,
    output reg bus_mode_o,
    output reg clk_master_o,
    output reg clock_lost_o,
    output reg bridge_a_o,
    output reg bridge_b_o,
    output reg audio_pass_o,
    output reg spread_en_o,
    output reg hop_en_o,
    output reg pll_en_o,
    output reg load_detect_en_o,
    output reg ext_cfg_en_o
);

// ==========================================================
// state codes
localparam [1:0] ST_OFF = `AMP_OFF;
localparam [1:0] ST_STANDBY = `AMP_STANDBY;
localparam [1:0] ST_MUTE = `AMP_MUTE;
localparam [1:0] ST_OPERATE = `AMP_OPERATE;

// ==========================================================
// pin synchronisers
localparam integer PIN_N = 6;
localparam integer PIN_ENABLE = 0;
localparam integer PIN_MUTE = 1;
localparam integer PIN_STRAP_BUS = 2;
localparam integer PIN_STRAP_CLK = 3;
localparam integer PIN_STRAP_AUX = 4;
localparam integer PIN_SHARED_CLK = 5;

// every pin is asynchronous to the core clock
wire [PIN_N-1:0] pin_raw = {shared_oscillator_pin_i, spread_or_pll_pin_i, oscillator_set_pin_i,
    address_select_pin_i, mute_select_pin_i, enable_pin_i};
reg [PIN_N-1:0] sync_a;
reg [PIN_N-1:0] sync_b;
reg osc_prev;
genvar gi;

// two flops per pin; the first may go metastable, so only the second is read
generate
    for (gi = 0; gi < PIN_N; gi = gi + 1) begin : g_pin_sync
        always @(posedge core_clk_i) begin
            if (rst_i) begin
                sync_a[gi] <= 1'b0;
                sync_b[gi] <= 1'b0;
            end else if (clk_en_i) begin
                sync_a[gi] <= pin_raw[gi];
                sync_b[gi] <= sync_a[gi];
            end
        end
    end
endgenerate

// last shared-pin level; starts low like the synchroniser, so no false edge after reset
always @(posedge core_clk_i) begin
    if (rst_i) begin
        osc_prev <= 1'b0;
    end else if (clk_en_i) begin
        osc_prev <= sync_b[PIN_SHARED_CLK];
    end
end

// synchronised pin levels
wire en_q = sync_b[PIN_ENABLE];
wire mute_q = sync_b[PIN_MUTE];
// strap high means a resistor is fitted; low means shorted to ground
wire bus_q = sync_b[PIN_STRAP_BUS];
wire master_q = sync_b[PIN_STRAP_CLK];
wire aux_q = sync_b[PIN_STRAP_AUX];
wire shared_q = sync_b[PIN_SHARED_CLK];
wire osc_edge = shared_q ^ osc_prev;

// ==========================================================
// internal oscillator (master source)
reg [7:0] div_cnt;
reg int_osc;

// free-running divider; keeps running so a master can feed slaves during shutdown
always @(posedge core_clk_i) begin
    if (rst_i) begin
        div_cnt <= 8'h00;
        int_osc <= 1'b0;
    end else if (clk_en_i) begin
        if (div_cnt == `OSC_DIV_HALF - 8'h01) begin
            div_cnt <= 8'h00;
            int_osc <= ~int_osc;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end
end

// selected pwm clock: own oscillator as master, synchronised pin as slave
// slave pwm rate is the synchronised pin, so it must stay well below half the core clock
wire sel_clk = master_q ? int_osc : shared_q;

// ==========================================================
// clock-loss watchdog
reg [`WDOG_CNT_W-1:0] wdog_cnt;
reg lost;

// core cycles since the last shared-pin edge; saturates at the limit
always @(posedge core_clk_i) begin
    if (rst_i) begin
        wdog_cnt <= {`WDOG_CNT_W{1'b0}};
    end else if (clk_en_i) begin
        if (master_q || !en_q || osc_edge) begin
            // armed only as an enabled slave; any edge restarts the count
            wdog_cnt <= {`WDOG_CNT_W{1'b0}};
        end else if (wdog_cnt != `WDOG_LAST_CNT) begin
            wdog_cnt <= wdog_cnt + {{(`WDOG_CNT_W-1){1'b0}}, 1'b1};
        end
    end
end

// sticky loss flag: a returning clock does not restart, only switch-off or the master strap clears it
always @(posedge core_clk_i) begin
    if (rst_i) begin
        lost <= 1'b0;
    end else if (clk_en_i) begin
        if (master_q || !en_q) begin
            lost <= 1'b0;
        end else if (!osc_edge && (wdog_cnt == `WDOG_LAST_CNT)) begin
            lost <= 1'b1;
        end
    end
end

// ==========================================================
// command latch
reg cmd1;
reg cmd2;
reg cmd_seen;

// command bits taken only while enabled in bus mode; lost on switch-off
always @(posedge core_clk_i) begin
    if (rst_i) begin
        cmd1 <= 1'b0;
        cmd2 <= 1'b0;
    end else if (clk_en_i) begin
        if (!en_q || !bus_q) begin
            cmd1 <= 1'b0;
            cmd2 <= 1'b0;
        end else if (cmd_valid_i) begin
            cmd1 <= first_cmd_byte_bit0_i;
            cmd2 <= second_cmd_byte_bit0_i;
        end
    end
end

// first accepted command ends the idle wait after enable
always @(posedge core_clk_i) begin
    if (rst_i) begin
        cmd_seen <= 1'b0;
    end else if (clk_en_i) begin
        if (!en_q || !bus_q) begin
            cmd_seen <= 1'b0;
        end else if (cmd_valid_i) begin
            cmd_seen <= 1'b1;
        end
    end
end

// ==========================================================
// state decode
reg [1:0] next_state;

// decode from enable, clock-loss flag, mute-select, strap and command bits
always @* begin
    next_state = ST_OFF;
    if (!en_q || lost) begin
        next_state = ST_OFF;
    end else if (!bus_q) begin
        // pin-only control: host drives both pins to reach operating
        next_state = mute_q ? ST_OPERATE : ST_MUTE;
    end else if (!cmd_seen) begin
        next_state = ST_STANDBY;
    end else if (mute_q && cmd1 && !cmd2) begin
        next_state = ST_OPERATE;
    end else if (!mute_q && cmd1 && cmd2) begin
        next_state = ST_MUTE;
    end else if (!mute_q && !cmd1) begin
        next_state = ST_STANDBY;
    end else begin
        // combinations outside the table fall back to the safe standby
        next_state = ST_STANDBY;
    end
end

// ==========================================================
// registered outputs
wire switching = (next_state == ST_MUTE) || (next_state == ST_OPERATE);

// state and status levels
always @(posedge core_clk_i) begin
    if (rst_i) begin
        amp_state_o <= ST_OFF;
        bus_mode_o <= 1'b0;
        clk_master_o <= 1'b0;
        clock_lost_o <= 1'b0;
        audio_pass_o <= 1'b0;
    end else if (clk_en_i) begin
        amp_state_o <= next_state;
        bus_mode_o <= bus_q;
        clk_master_o <= master_q;
        clock_lost_o <= lost;
        audio_pass_o <= (next_state == ST_OPERATE);
    end
end

// shared pin drive; the divider runs on in shutdown so slaves can finish switching off
always @(posedge core_clk_i) begin
    if (rst_i) begin
        shared_oscillator_pin_o <= 1'b0;
        shared_oscillator_pin_oe_o <= 1'b0;
    end else if (clk_en_i) begin
        shared_oscillator_pin_o <= master_q & int_osc;
        shared_oscillator_pin_oe_o <= master_q;
    end
end

// idle 50% duty in mute and operate: halves in opposite phase, no audio
always @(posedge core_clk_i) begin
    if (rst_i) begin
        bridge_a_o <= 1'b0;
        bridge_b_o <= 1'b0;
    end else if (clk_en_i) begin
        bridge_a_o <= switching & sel_clk;
        bridge_b_o <= switching & ~sel_clk;
    end
end

// feature enables gated by clock role and control mode
always @(posedge core_clk_i) begin
    if (rst_i) begin
        spread_en_o <= 1'b0;
        hop_en_o <= 1'b0;
        pll_en_o <= 1'b0;
        load_detect_en_o <= 1'b0;
        ext_cfg_en_o <= 1'b0;
    end else if (clk_en_i) begin
        spread_en_o <= master_q & aux_q;
        pll_en_o <= ~master_q & aux_q;
        hop_en_o <= master_q & bus_q & en_q & hop_req_i;
        load_detect_en_o <= bus_q & en_q & load_detect_req_i;
        ext_cfg_en_o <= bus_q & en_q & ext_cfg_req_i;
    end
end

endmodule
`default_nettype wire

// File: tb/amp_mode_ctrl_properties.sv
// concurrent checks on the mode control ports
`timescale 1ns/10ps
`default_nettype none
module amp_mode_checker (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic enable_pin_i,
    input wire logic [1:0] amp_state_o,
    input wire logic audio_pass_o,
    input wire logic bridge_a_o,
    input wire logic bridge_b_o,
    input wire logic clk_master_o,
    input wire logic shared_oscillator_pin_o,
    input wire logic shared_oscillator_pin_oe_o,
    input wire logic spread_en_o,
    input wire logic pll_en_o,
    input wire logic hop_en_o,
    input wire logic bus_mode_o,
    input wire logic clock_lost_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // steps: pin low through the synchroniser, master held
    sequence en_low_s; !enable_pin_i [*4]; endsequence
    sequence master_s; clk_master_o [*2]; endsequence
    sequence bridged_s; amp_state_o[1] && $past(amp_state_o[1]); endsequence
    AST_OFF_WHEN_DISABLED: assert property (en_low_s |-> amp_state_o == 2'h0) else $error("active while disabled");
    AST_AUDIO_OPERATE_ONLY: assert property (audio_pass_o |-> amp_state_o == 2'h3) else $error("audio outside operate");
    AST_BRIDGE_SWITCHING: assert property (bridged_s |-> bridge_a_o != bridge_b_o) else $error("bridges not toggling");
    AST_MASTER_DRIVES_PIN: assert property (shared_oscillator_pin_oe_o == clk_master_o) else $error("pin drive wrong");
    AST_MASTER_CLOCK_OUT: assert property (master_s |-> ##[1:160] $changed(shared_oscillator_pin_o)) else $error("no clock out");
    AST_SPREAD_MASTER: assert property (spread_en_o || hop_en_o |-> clk_master_o) else $error("spread in slave");
    AST_PLL_SLAVE: assert property (pll_en_o |-> !clk_master_o) else $error("pll in master");
    AST_HOP_BUS_ONLY: assert property (hop_en_o |-> bus_mode_o) else $error("hop outside bus mode");
    AST_LOSS_FORCES_OFF: assert property (clock_lost_o |-> ##[0:2] amp_state_o == 2'h0) else $error("on after loss");
endmodule
bind amp_mode_ctrl amp_mode_checker chk_u (.*);
`default_nettype wire

// File: tb/ext_osc_source.sv
// external clock source model feeding the shared oscillator pin
`timescale 1ns/10ps
`default_nettype none
module ext_osc_source (
    input wire logic core_clk_i,
    input wire logic run_i,
    output logic osc_o
);
    logic [4:0] cnt = 5'h00;
    initial osc_o = 1'b0;
    // keeps running until the bench stops it, so slaves can finish shutdown
    always @(posedge core_clk_i) begin
        if (run_i) begin
            cnt <= (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
            if (cnt == 5'h13) begin
                osc_o <= ~osc_o;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/test_amp_mode_ctrl.sv
// testbench for the amplifier mode and clock source control
`timescale 1ns/10ps
`default_nettype none
module test_amp_mode_ctrl;
    logic core_clk_i = 1'b0, rst_i = 1'b1, clk_en_i = 1'b1, enable_pin_i = 1'b0, mute_select_pin_i = 1'b1;
    logic address_select_pin_i = 1'b1, oscillator_set_pin_i = 1'b0, spread_or_pll_pin_i = 1'b1, cmd_valid_i = 1'b0;
    logic first_cmd_byte_bit0_i = 1'b0, second_cmd_byte_bit0_i = 1'b0, hop_req_i = 1'b1, load_detect_req_i = 1'b1;
    logic ext_cfg_req_i = 1'b1, run = 1'b1, ext_osc, shared_oscillator_pin_o, shared_oscillator_pin_oe_o, bus_mode_o;
    logic clk_master_o, clock_lost_o, bridge_a_o, bridge_b_o, audio_pass_o, spread_en_o, hop_en_o, pll_en_o;
    logic load_detect_en_o, ext_cfg_en_o;
    logic [1:0] amp_state_o;
    int failures = 0, compares = 0;
    // only one party drives the shared pin at a time
    wire logic shared_oscillator_pin_i = shared_oscillator_pin_oe_o ? shared_oscillator_pin_o : ext_osc;
    amp_mode_ctrl dut_u (.*);
    ext_osc_source src_u (.core_clk_i(core_clk_i), .run_i(run), .osc_o(ext_osc));
    // ==========================================
    // clock and tasks
    initial forever #5 core_clk_i = ~core_clk_i;
    task automatic step(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle command pulse, then time for latch and output flop
    task automatic cmd(input logic b1, input logic b2);
        first_cmd_byte_bit0_i = b1;
        second_cmd_byte_bit0_i = b2;
        cmd_valid_i = 1'b1;
        step(1);
        cmd_valid_i = 1'b0;
        step(4);
    endtask
    task automatic give_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        step(12);
        rst_i = 1'b0;
        cmd(1'b1, 1'b0);
        chk(amp_state_o, 2'h0);
        enable_pin_i = 1'b1;
        step(5);
        chk({bus_mode_o, amp_state_o[0]}, 2'h3);
        cmd(1'b1, 1'b0);
        chk({audio_pass_o, amp_state_o[0]}, 2'h3);
        mute_select_pin_i = 1'b0;
        cmd(1'b1, 1'b1);
        chk(amp_state_o, 2'h2);
        cmd(1'b0, 1'b1);
        chk(amp_state_o, 2'h1);
        address_select_pin_i = 1'b0;
        step(5);
        chk(amp_state_o, 2'h2);
        chk({hop_en_o, ext_cfg_en_o}, 2'h0);
        chk({load_detect_en_o, audio_pass_o}, 2'h0);
        mute_select_pin_i = 1'b1;
        step(5);
        chk(amp_state_o, 2'h3);
        address_select_pin_i = 1'b1;
        oscillator_set_pin_i = 1'b1;
        step(5);
        chk({clk_master_o, shared_oscillator_pin_oe_o}, 2'h3);
        chk({spread_en_o, hop_en_o}, 2'h3);
        chk({ext_cfg_en_o, pll_en_o}, 2'h2);
        chk({load_detect_en_o, bridge_a_o | bridge_b_o}, 2'h2);
        step(160);
        oscillator_set_pin_i = 1'b0;
        step(5);
        chk({pll_en_o, clk_master_o}, 2'h2);
        chk({shared_oscillator_pin_oe_o, shared_oscillator_pin_o}, 2'h0);
        run = 1'b0;
        step(1010);
        chk({clock_lost_o, amp_state_o[0]}, 2'h2);
        enable_pin_i = 1'b0;
        run = 1'b1;
        step(5);
        chk({clock_lost_o, amp_state_o[0]}, 2'h0);
        give_verdict;
    end
    // watchdog against a hang
    initial begin
        #200us;
        failures++;
        give_verdict;
    end
endmodule
`default_nettype wire
